// [hw/cgcb_clock_gate.v]
// Per-output clock gating driven by the enable bits
module cgcb_clock_gate (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [8:0] src_clocks_i,
  input  wire [8:0] enables_i,
  output wire [8:0] gated_clocks_o
);

  reg [8:0] gated_r;

  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : gate
      always @(posedge clk_i) begin
        if (rst_i) begin
          gated_r[g] <= 1'b0;
        end else begin
          gated_r[g] <= src_clocks_i[g] & enables_i[g];
        end
      end
    end
  endgenerate

  assign gated_clocks_o = gated_r;

endmodule

// [hw/cgcb_defines.vh]
// Offsets, field positions, reset values and codes of the clock generator config bytes
`ifndef CGCB_DEFINES_VH
`define CGCB_DEFINES_VH

// Byte offsets carried in the low seven command bits
`define CGCB_OFS_OUT_EN      7'h03
`define CGCB_OFS_MULT_REF    7'h04
`define CGCB_OFS_SPREAD_FSEL 7'h05
`define CGCB_OFS_IDENT       7'h06
`define CGCB_OFS_RSVD7       7'h07

// Command code layout
`define CGCB_CMD_BYTE_BIT    7

// Output enable byte fields
`define CGCB_B3_USB_EN       7
`define CGCB_B3_48M_EN       6
`define CGCB_B3_SHARED_FSEL  3
`define CGCB_B3_SHARED_EN    2
`define CGCB_B3_FREE1_EN     1
`define CGCB_B3_FREE0_EN     0
`define CGCB_B3_MASK         8'hCF
`define CGCB_B3_RESET        8'hC7

// Multiplier and reference byte fields
`define CGCB_B4_MULT_SW      7
`define CGCB_B4_MULT_HI      6
`define CGCB_B4_MULT_LO      5
`define CGCB_B4_REF_EN       4
`define CGCB_B4_REFERENCE_DRIVE_STRENGTH      3
`define CGCB_B4_HUB3_EN      2
`define CGCB_B4_HUB2_EN      1
`define CGCB_B4_HUB1_EN      0
`define CGCB_B4_MASK         8'hFF
`define CGCB_B4_RESET        8'h17

// Spread option and frequency select byte fields
`define CGCB_B5_SPREAD_HI    7
`define CGCB_B5_SPREAD_LO    6
`define CGCB_B5_USB_FSEL     0
`define CGCB_B5_MASK         8'hC1
`define CGCB_B5_RESET        8'h01

// Identification byte fields
`define CGCB_ID_REV_HI       7
`define CGCB_ID_REV_LO       4
`define CGCB_ID_MAKER_HI     3
`define CGCB_ID_MAKER_LO     0

// Current multiplier base: code 00 gives four times the reference current
`define CGCB_MULT_BASE       3'h4

// Number of gated clock outputs
`define CGCB_NUM_CLKS        9

`endif

// [hw/cgcb_top.v]
// Management bus slave and configuration register bytes of the clock generator
// Functional notes
// - Multiplier comes from pins when override bit is 0, else bits 6:5.
// - Software multiplier codes 00..11 give four to seven times reference current.
// - Shared output runs 66 MHz with select 0, 48 MHz with 1; default 66.
// - Dual rate output gives 24 MHz at 0, 48 MHz at 1; default 1.
// - Reference output drive normal at 0, high at 1; resets to 0.
// - Identification byte: fixed maker nibble low, revision nibble high; writes ignored.
// - Command code with top bit 1 selects byte access; low seven bits give offset.
`include "cgcb_defines.vh"

module cgcb_top #(
  parameter [6:0] SLAVE_ADDR = 7'h5A,
  parameter [3:0] MAKER_CODE = 4'h5,
  parameter [3:0] REV_CODE   = 4'h0
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_n_o,
  input  wire [1:0] current_mult_pins_i,
  input  wire [8:0] src_clocks_i,
  output wire [8:0] gated_clocks_o,
  output reg  [2:0] iref_multiple_o,
  output reg        shared_66_48_sel_o,
  output reg        dual_rate_usb_sel_o,
  output reg        reference_drive_strength_o,
  output reg  [1:0] spread_option_o
);

  // MAKER_CODE and REV_CODE values are arbitrary

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_CMD   = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_MACK  = 3'h5;
  localparam [2:0] ST_WAIT  = 3'h6;

  reg  [2:0] state_r;
  reg  [3:0] bcnt_r;
  reg  [7:0] shift_r;
  reg        ack_slot_r;
  reg        read_r;
  reg  [6:0] index_r;
  reg        sda_low_r;
  reg        scl_d_r;
  reg        sda_d_r;
  reg  [7:0] out_en_r;
  reg  [7:0] mult_ref_r;
  reg  [7:0] spread_fsel_r;
  reg  [7:0] rdata;
  reg  [1:0] mult_code;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire [8:0] enables;

  assign scl_rise  = scl_i & ~scl_d_r;
  assign scl_fall  = ~scl_i & scl_d_r;
  assign start_det = scl_i & scl_d_r & sda_d_r & ~sda_i;
  assign stop_det  = scl_i & scl_d_r & ~sda_d_r & sda_i;

  // Open-drain data pin: only ever pulls low
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~sda_low_r;

  // Read data by offset
  always @* begin
    case (index_r)
      `CGCB_OFS_OUT_EN:      rdata = out_en_r;
      `CGCB_OFS_MULT_REF:    rdata = mult_ref_r;
      `CGCB_OFS_SPREAD_FSEL: rdata = spread_fsel_r;
      `CGCB_OFS_IDENT:       rdata = {REV_CODE, MAKER_CODE};
      default:               rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
    end
  end

  // Bus protocol and register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r       <= ST_IDLE;
      bcnt_r        <= 4'h0;
      shift_r       <= 8'h00;
      ack_slot_r    <= 1'b0;
      read_r        <= 1'b0;
      index_r       <= 7'h00;
      sda_low_r     <= 1'b0;
      out_en_r      <= `CGCB_B3_RESET;
      mult_ref_r    <= `CGCB_B4_RESET;
      spread_fsel_r <= `CGCB_B5_RESET;
    end else if (start_det) begin
      state_r    <= ST_ADDR;
      bcnt_r     <= 4'h0;
      ack_slot_r <= 1'b0;
      sda_low_r  <= 1'b0;
    end else if (stop_det) begin
      state_r    <= ST_IDLE;
      ack_slot_r <= 1'b0;
      sda_low_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise && !ack_slot_r && bcnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_i};
            bcnt_r  <= bcnt_r + 4'h1;
          end else if (scl_fall && ack_slot_r) begin
            ack_slot_r <= 1'b0;
            bcnt_r     <= 4'h0;
            if (state_r == ST_ADDR && read_r) begin
              state_r   <= ST_RDATA;
              shift_r   <= rdata;
              sda_low_r <= ~rdata[7];
            end else if (state_r == ST_ADDR) begin
              state_r   <= ST_CMD;
              sda_low_r <= 1'b0;
            end else if (state_r == ST_CMD) begin
              state_r   <= ST_WDATA;
              sda_low_r <= 1'b0;
            end else begin
              state_r   <= ST_WAIT;
              sda_low_r <= 1'b0;
            end
          end else if (scl_fall && bcnt_r == 4'h8) begin
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == SLAVE_ADDR) begin
                read_r     <= shift_r[0];
                ack_slot_r <= 1'b1;
                sda_low_r  <= 1'b1;
              end else begin
                state_r <= ST_WAIT;
              end
            end else if (state_r == ST_CMD) begin
              if (shift_r[`CGCB_CMD_BYTE_BIT]) begin
                index_r    <= shift_r[6:0];
                ack_slot_r <= 1'b1;
                sda_low_r  <= 1'b1;
              end else begin
                state_r <= ST_WAIT;
              end
            end else begin
              ack_slot_r <= 1'b1;
              sda_low_r  <= 1'b1;
              case (index_r)
                `CGCB_OFS_OUT_EN:      out_en_r      <= shift_r & `CGCB_B3_MASK;
                `CGCB_OFS_MULT_REF:    mult_ref_r    <= shift_r & `CGCB_B4_MASK;
                `CGCB_OFS_SPREAD_FSEL: spread_fsel_r <= shift_r & `CGCB_B5_MASK;
                default:               out_en_r      <= out_en_r;
              endcase
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && bcnt_r != 4'h8) begin
            bcnt_r <= bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == 4'h8) begin
            sda_low_r <= 1'b0;
            state_r   <= ST_MACK;
          end else if (scl_fall) begin
            sda_low_r <= ~shift_r[3'h7 - bcnt_r[2:0]];
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            bcnt_r  <= 4'h0;
            state_r <= sda_i ? ST_WAIT : ST_RDATA;
            shift_r <= rdata;
          end
        end
        ST_IDLE, ST_WAIT: begin
          sda_low_r <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration outputs
  always @* begin
    if (mult_ref_r[`CGCB_B4_MULT_SW]) begin
      mult_code = {mult_ref_r[`CGCB_B4_MULT_HI], mult_ref_r[`CGCB_B4_MULT_LO]};
    end else begin
      mult_code = current_mult_pins_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      iref_multiple_o            <= `CGCB_MULT_BASE;
      shared_66_48_sel_o         <= 1'b0;
      dual_rate_usb_sel_o        <= 1'b1;
      reference_drive_strength_o <= 1'b0;
      spread_option_o            <= 2'h0;
    end else begin
      iref_multiple_o            <= `CGCB_MULT_BASE + {1'b0, mult_code};
      shared_66_48_sel_o         <= out_en_r[`CGCB_B3_SHARED_FSEL];
      dual_rate_usb_sel_o        <= spread_fsel_r[`CGCB_B5_USB_FSEL];
      reference_drive_strength_o <= mult_ref_r[`CGCB_B4_REFERENCE_DRIVE_STRENGTH];
      spread_option_o            <= {spread_fsel_r[`CGCB_B5_SPREAD_HI],
                                     spread_fsel_r[`CGCB_B5_SPREAD_LO]};
    end
  end

  assign enables = {out_en_r[`CGCB_B3_USB_EN], out_en_r[`CGCB_B3_48M_EN],
                    out_en_r[`CGCB_B3_SHARED_EN], out_en_r[`CGCB_B3_FREE1_EN],
                    out_en_r[`CGCB_B3_FREE0_EN], mult_ref_r[`CGCB_B4_REF_EN],
                    mult_ref_r[`CGCB_B4_HUB3_EN], mult_ref_r[`CGCB_B4_HUB2_EN],
                    mult_ref_r[`CGCB_B4_HUB1_EN]};

  cgcb_clock_gate u_gate (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .src_clocks_i   (src_clocks_i),
    .enables_i      (enables),
    .gated_clocks_o (gated_clocks_o)
  );

endmodule

// [verif/cgcb_host_model.sv]
// Management bus host model driving bus clock and open drain data
module cgcb_host_model #(parameter int H = 4) (
  input  logic clk_i,
  input  logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    scl_o <= c;
    sda_o <= d;
    repeat (H) @(posedge clk_i);
  endtask
  // Lower the bus clock first so that a repeated start follows a clean low phase
  task automatic start();
    step(1'b0, sda_o);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
                      output logic a);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, sda_o);
      step(1'b0, i == 0 ? m : d[i-1]);
      step(1'b1, sda_o);
      if (i == 0)
        a = sda_i;
      else
        q[i-1] = sda_i;
    end
  endtask
endmodule

// [verif/cgcb_top_assertions.sv]
// Port checks for the clock generator config bytes
module cgcb_top_chk (
  input logic       clk_i,
  input logic       rst_i,
  input logic       scl_i,
  input logic       sda_oe_n_o,
  input logic [1:0] current_mult_pins_i,
  input logic [8:0] src_clocks_i,
  input logic [8:0] gated_clocks_o,
  input logic [2:0] iref_multiple_o,
  input logic       shared_66_48_sel_o,
  input logic       dual_rate_usb_sel_o,
  input logic       reference_drive_strength_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_scl_low_late;
    !$past(scl_i) || !$past(scl_i, 2);
  endsequence
  chk_mult_reset: assert property ($fell(rst_i) |-> iref_multiple_o == 3'h4)
    else $error("multiplier not at reset value");
  chk_sel_reset: assert property (
    $fell(rst_i) |-> !shared_66_48_sel_o && dual_rate_usb_sel_o)
    else $error("select outputs not at reset values");
  chk_drive_reset: assert property ($fell(rst_i) |-> !reference_drive_strength_o)
    else $error("drive strength not normal after reset");
  chk_mult_range: assert property (iref_multiple_o[2])
    else $error("multiplier below four");
  chk_gate_source: assert property (
    (gated_clocks_o & ~$past(src_clocks_i)) == 9'h000)
    else $error("gated clock high without source");
  chk_ack_edge: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i))
    else $error("data pull changed while bus clock high");
  chk_sel_update: assert property (
    $changed({shared_66_48_sel_o, dual_rate_usb_sel_o, reference_drive_strength_o})
    |-> s_scl_low_late)
    else $error("select changed outside a bus clock low phase");
  chk_mult_cause: assert property (
    $changed(iref_multiple_o) && !$past(rst_i, 2) |->
    s_scl_low_late or (current_mult_pins_i != $past(current_mult_pins_i, 3)))
    else $error("multiplier changed without cause");
endmodule
bind cgcb_top cgcb_top_chk cgcb_top_chk_inst (.*);

// [verif/cgcb_top_tb.sv]
// Self-checking bench for the clock generator config bytes
`include "cgcb_defines.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module cgcb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] SLV = 7'h5A;
  logic clk_i = 0, rst_i = 1, scl_i, hsda, sda_o, sda_oe_n_o;
  logic [1:0] current_mult_pins_i = 2'h0, spread_option_o;
  logic [8:0] src_clocks_i = 9'h000, gated_clocks_o;
  logic [2:0] iref_multiple_o;
  logic shared_66_48_sel_o, dual_rate_usb_sel_o, reference_drive_strength_o;
  int n_mismatch = 0, checked = 0;
  logic [7:0] mdl [0:7];
  wire sda_i = hsda & sda_oe_n_o;
  cgcb_top cgcb_top_inst (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .scl_i                      (scl_i),
    .sda_i                      (sda_i),
    .sda_o                      (sda_o),
    .sda_oe_n_o                 (sda_oe_n_o),
    .current_mult_pins_i        (current_mult_pins_i),
    .src_clocks_i               (src_clocks_i),
    .gated_clocks_o             (gated_clocks_o),
    .iref_multiple_o            (iref_multiple_o),
    .shared_66_48_sel_o         (shared_66_48_sel_o),
    .dual_rate_usb_sel_o        (dual_rate_usb_sel_o),
    .reference_drive_strength_o (reference_drive_strength_o),
    .spread_option_o            (spread_option_o)
  );
  cgcb_host_model host (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_o(hsda));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    mdl = '{8'h00, 8'h00, 8'h00, 8'hC7, 8'h17, 8'h01, 8'h05, 8'h00};
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
    logic [7:0] q;
    logic k1, k2, k3;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, k1);
    host.xfer(c, 1'b1, q, k2);
    host.xfer(d, 1'b1, q, k3);
    host.stop();
    `CHK("ack addr", a != SLV, k1)
    `CHK("ack cmd", !(a == SLV && c[7]), k2)
    `CHK("ack data", !(a == SLV && c[7]), k3)
    if (a == SLV && c[7])
      case (c[6:0])
        7'h03: mdl[3] = d & `CGCB_B3_MASK;
        7'h04: mdl[4] = d;
        7'h05: mdl[5] = d & `CGCB_B5_MASK;
        default: ;
      endcase
  endtask
  task automatic rd(input logic [6:0] o);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer({SLV, 1'b0}, 1'b1, q, k);
    host.xfer({1'b1, o}, 1'b1, q, k);
    host.start();
    host.xfer({SLV, 1'b1}, 1'b1, q, k);
    host.xfer(8'hFF, 1'b1, q, k);
    host.stop();
    `CHK("read", mdl[o], q)
  endtask
  task automatic chk_out();
    logic [8:0] en;
    en = {mdl[3][7:6], mdl[3][2:0], mdl[4][4], mdl[4][2:0]};
    src_clocks_i <= 9'($urandom);
    repeat (3) @(posedge clk_i);
    `CHK("gated", src_clocks_i & en, gated_clocks_o)
    `CHK("iref", mdl[4][7] ? 3'h4 + mdl[4][6:5] : 3'h4 + current_mult_pins_i,
         iref_multiple_o)
    `CHK("sel66", mdl[3][3], shared_66_48_sel_o)
    `CHK("sel24", mdl[5][0], dual_rate_usb_sel_o)
    `CHK("drive", mdl[4][3], reference_drive_strength_o)
    `CHK("spread", mdl[5][7:6], spread_option_o)
    `CHK("sda value", 1'b0, sda_o)
    `CHK("sda release", 1'b1, sda_oe_n_o)
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(68));
    do_reset();
    chk_out();
    for (int i = 0; i < 8; i++) begin
      current_mult_pins_i <= 2'($urandom);
      wr(SLV, 8'h83, 8'($urandom));
      wr(SLV, 8'h84, {i[2], i[1:0], 5'($urandom)});
      wr(SLV, 8'h85, 8'($urandom));
      chk_out();
      for (int j = 3; j < 6; j++)
        rd(j[6:0]);
    end
    // Refused command, foreign address, read-only and unmapped bytes
    wr(SLV, 8'h03, 8'h00);
    wr(SLV ^ 7'h01, 8'h83, 8'h00);
    wr(SLV, 8'h86, 8'hFF);
    wr(SLV, 8'h87, 8'hFF);
    wr(SLV, 8'h80, 8'hFF);
    for (int j = 0; j < 8; j++)
      rd(j[6:0]);
    chk_out();
    do_reset();
    for (int j = 3; j < 7; j++)
      rd(j[6:0]);
    chk_out();
    close_out();
  end
endmodule
